// ==== inc/sc_pkg.sv ====
// Operation
// - active detection plus access to a prohibited range raises an internal reset
// - guard control bit 7 set enables illegal-access detection, a written 0 does not disable it
// - detection enable sets on a written 1 and stays set until reset
// - watchdog-run option of 1 forces detection on even with enable bit clear
// - guard control takes byte writes and clears to zero on any reset
// - ram guard field blocks writes to 128, 256 or 512 bytes, reads pass
// - port, interrupt and clock guard bits each block writes to their group
// - timer input select clears at reset, byte writes, low bits choose channel 1
// - code 000 selects the external pin, 100 the slow oscillator, others prohibited
// - output-mode port reads give latch when readback bit clear, pin when set
// - readback select takes bit or byte writes, bits 7..1 zero, resets to zero
// - port 6 pins 0..4 as general ports read 0 in output mode under pin readback; input-mode pins read the pin
// - converter test field 00 normal channel, 10 negative ref, 11 positive ref
package sc_pkg;

  // --------------------------------------------------------------------------
  // register map
  // --------------------------------------------------------------------------
  localparam logic [19:0] SC_ADDR_TIMER_SEL = 20'hF_0074;
  localparam logic [19:0] SC_ADDR_GUARD_CTL = 20'hF_0077;
  localparam logic [19:0] SC_ADDR_READBACK = 20'hF_007B;
  localparam logic [19:0] SC_ADDR_CONV_TEST = 20'hF_0013;
  localparam logic [7:0] SC_RESET_BYTE = 8'h00;

  // --------------------------------------------------------------------------
  // field layout
  // --------------------------------------------------------------------------
  localparam int SC_BIT_DETECT_EN = 7;
  localparam int SC_BIT_RAM_HI = 5;
  localparam int SC_BIT_RAM_LO = 4;
  localparam int SC_BIT_PORT_GUARD = 2;
  localparam int SC_BIT_IRQ_GUARD = 1;
  localparam int SC_BIT_CSC_GUARD = 0;
  localparam int SC_BIT_READBACK = 0;
  localparam int SC_BIT_TEST_HI = 1;
  localparam int SC_BIT_TEST_LO = 0;
  localparam int SC_P6_GP_BITS = 5;

  // --------------------------------------------------------------------------
  // timer input select codes
  // --------------------------------------------------------------------------
  localparam logic [2:0] SC_TIS_EXT_PIN = 3'h0;
  localparam logic [2:0] SC_TIS_LOW_OSC = 3'h4;

  // --------------------------------------------------------------------------
  // ram guard sizes and address ranges
  // --------------------------------------------------------------------------
  localparam logic [1:0] SC_RAM_GUARD_OFF = 2'h0;
  localparam logic [1:0] SC_RAM_GUARD_128 = 2'h1;
  localparam logic [1:0] SC_RAM_GUARD_256 = 2'h2;
  localparam logic [19:0] SC_SIZE_128 = 20'h0_0080;
  localparam logic [19:0] SC_SIZE_256 = 20'h0_0100;
  localparam logic [19:0] SC_SIZE_512 = 20'h0_0200;
  localparam logic [19:0] SC_RAM_START = 20'hF_F700;
  localparam logic [19:0] SC_NG_BASE = 20'hE_0000;
  localparam logic [19:0] SC_NG_SIZE = 20'h1_0000;

  // --------------------------------------------------------------------------
  // converter test source
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SC_SRC_CHANNEL = 2'b00,
    SC_SRC_NEG_REF = 2'b10,
    SC_SRC_POS_REF = 2'b11
  } sc_conv_src_t;

  // range test shared by the prohibited window and the ram guard
  function automatic logic sc_in_range(input logic [19:0] a, input logic [19:0] lo,
                                       input logic [19:0] size);
    sc_in_range = (a >= lo) && (a < lo + size);
  endfunction : sc_in_range

endpackage : sc_pkg

// ==== design/sc_sync2.sv ====
`timescale 1ns/1ps
module sc_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else if (ce) begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule : sc_sync2

// ==== design/sc_safety_ctl.sv ====
`timescale 1ns/1ps
module sc_safety_ctl (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // register bus
  input wire logic [19:0] bus_addr,
  input wire logic bus_wr_byte,
  input wire logic bus_wr_bit,
  input wire logic bus_rd,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  // memory access monitor
  input wire logic mem_valid,
  input wire logic mem_write,
  input wire logic [19:0] mem_addr,
  input wire logic mem_grp_port,
  input wire logic mem_grp_irq,
  input wire logic mem_grp_csc,
  output logic mem_wr_block,
  // option byte and reset controller
  input wire logic watchdog_run_option,
  output logic illegal_access_reset_req,
  // timer unit channel 1
  input wire logic chan1_external_input,
  input wire logic low_speed_osc_clock,
  output logic chan1_capture_in,
  // port readback
  input wire logic [7:0] port_latch,
  input wire logic [7:0] port_pin_level,
  input wire logic [7:0] port_direction_register,
  input wire logic port_is_p6_gp,
  output logic [7:0] port_read_data,
  // converter test source
  output logic [1:0] converter_test_source
);

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  logic detect_en_ff;
  logic [1:0] ram_guard_ff;
  logic port_guard_ff;
  logic irq_guard_ff;
  logic csc_guard_ff;
  logic [2:0] timer_sel_ff;
  logic readback_ff;
  logic [1:0] conv_test_ff;
  logic wdt_opt_ff;
  logic opt_taken_ff;
  logic fired_ff;
  logic reset_req_ff;
  logic chan1_ff;
  logic [7:0] port_rd_ff;
  logic [7:0] rdata_ff;

  // --------------------------------------------------------------------------
  // synchronisers
  // --------------------------------------------------------------------------
  logic ext_sync;
  logic losc_sync;
  logic [7:0] pin_sync;

  sc_sync2 #(.WIDTH(1)) u_sync_ext (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .async_in(chan1_external_input),
    .sync_out(ext_sync)
  );

  sc_sync2 #(.WIDTH(1)) u_sync_losc (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .async_in(low_speed_osc_clock),
    .sync_out(losc_sync)
  );

  sc_sync2 #(.WIDTH(8)) u_sync_pin (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .async_in(port_pin_level),
    .sync_out(pin_sync)
  );

  // --------------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------------
  wire sel_timer = (bus_addr == sc_pkg::SC_ADDR_TIMER_SEL);
  wire sel_guard = (bus_addr == sc_pkg::SC_ADDR_GUARD_CTL);
  wire sel_readback = (bus_addr == sc_pkg::SC_ADDR_READBACK);
  wire sel_conv = (bus_addr == sc_pkg::SC_ADDR_CONV_TEST);
  wire wr_guard = ce && bus_wr_byte && sel_guard;
  wire wr_timer = ce && bus_wr_byte && sel_timer;
  wire wr_readback = ce && (bus_wr_byte || bus_wr_bit) && sel_readback;
  wire wr_conv = ce && bus_wr_byte && sel_conv;

  // --------------------------------------------------------------------------
  // register file
  // --------------------------------------------------------------------------
  // the enable only ever moves to 1; a written 0 leaves it alone
  wire nxt_detect_en = detect_en_ff ||
                       (wr_guard && bus_wdata[sc_pkg::SC_BIT_DETECT_EN]);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      detect_en_ff <= 1'b0;
      ram_guard_ff <= sc_pkg::SC_RAM_GUARD_OFF;
      port_guard_ff <= 1'b0;
      irq_guard_ff <= 1'b0;
      csc_guard_ff <= 1'b0;
    end else if (ce) begin
      detect_en_ff <= nxt_detect_en;
      if (wr_guard) begin
        ram_guard_ff <= {bus_wdata[sc_pkg::SC_BIT_RAM_HI], bus_wdata[sc_pkg::SC_BIT_RAM_LO]};
        port_guard_ff <= bus_wdata[sc_pkg::SC_BIT_PORT_GUARD];
        irq_guard_ff <= bus_wdata[sc_pkg::SC_BIT_IRQ_GUARD];
        csc_guard_ff <= bus_wdata[sc_pkg::SC_BIT_CSC_GUARD];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      timer_sel_ff <= sc_pkg::SC_TIS_EXT_PIN;
      readback_ff <= 1'b0;
      conv_test_ff <= sc_pkg::SC_SRC_CHANNEL;
    end else if (ce) begin
      if (wr_timer) begin
        timer_sel_ff <= bus_wdata[2:0];
      end
      if (wr_readback) begin
        readback_ff <= bus_wdata[sc_pkg::SC_BIT_READBACK];
      end
      if (wr_conv) begin
        conv_test_ff <= {bus_wdata[sc_pkg::SC_BIT_TEST_HI], bus_wdata[sc_pkg::SC_BIT_TEST_LO]};
      end
    end
  end

  // --------------------------------------------------------------------------
  // read path
  // --------------------------------------------------------------------------
  wire [7:0] guard_byte = {detect_en_ff, 1'b0, ram_guard_ff, 1'b0, port_guard_ff,
                           irq_guard_ff, csc_guard_ff};
  wire [7:0] timer_byte = {5'h0_0, timer_sel_ff};
  wire [7:0] readback_byte = {7'h00, readback_ff};
  wire [7:0] conv_byte = {6'h00, conv_test_ff};
  wire [7:0] nxt_rdata = sel_guard ? guard_byte :
                         sel_timer ? timer_byte :
                         sel_readback ? readback_byte :
                         sel_conv ? conv_byte : sc_pkg::SC_RESET_BYTE;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_ff <= sc_pkg::SC_RESET_BYTE;
    end else if (ce && bus_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign bus_rdata = rdata_ff;

  // --------------------------------------------------------------------------
  // option capture and illegal-access detector
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wdt_opt_ff <= 1'b0;
      opt_taken_ff <= 1'b0;
    end else if (ce && !opt_taken_ff) begin
      wdt_opt_ff <= watchdog_run_option;
      opt_taken_ff <= 1'b1;
    end
  end

  wire detect_active = detect_en_ff || wdt_opt_ff;
  wire ng_hit = mem_valid && sc_pkg::sc_in_range(mem_addr, sc_pkg::SC_NG_BASE,
                                                 sc_pkg::SC_NG_SIZE);
  wire fire = detect_active && ng_hit && !fired_ff;

  // one pulse per reset; the reset controller clears fired_ff by resetting us
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fired_ff <= 1'b0;
      reset_req_ff <= 1'b0;
    end else if (ce) begin
      fired_ff <= fired_ff || fire;
      reset_req_ff <= fire;
    end
  end

  assign illegal_access_reset_req = reset_req_ff;

  // --------------------------------------------------------------------------
  // ram and register-group write guard
  // --------------------------------------------------------------------------
  wire [19:0] ram_size = (ram_guard_ff == sc_pkg::SC_RAM_GUARD_128) ? sc_pkg::SC_SIZE_128 :
                         (ram_guard_ff == sc_pkg::SC_RAM_GUARD_256) ? sc_pkg::SC_SIZE_256 :
                         sc_pkg::SC_SIZE_512;
  wire ram_hit = (ram_guard_ff != sc_pkg::SC_RAM_GUARD_OFF) &&
                 sc_pkg::sc_in_range(mem_addr, sc_pkg::SC_RAM_START, ram_size);
  wire grp_hit = (port_guard_ff && mem_grp_port) || (irq_guard_ff && mem_grp_irq) ||
                 (csc_guard_ff && mem_grp_csc);
  assign mem_wr_block = mem_valid && mem_write && (ram_hit || grp_hit);

  // --------------------------------------------------------------------------
  // timer channel 1 source
  // --------------------------------------------------------------------------
  // prohibited codes feed a steady low
  wire nxt_chan1 = (timer_sel_ff == sc_pkg::SC_TIS_EXT_PIN) ? ext_sync :
                   (timer_sel_ff == sc_pkg::SC_TIS_LOW_OSC) ? losc_sync : 1'b0;

  // --------------------------------------------------------------------------
  // port readback
  // --------------------------------------------------------------------------
  // direction 0 is output mode; input-mode pins always show the pin
  wire [7:0] out_mode = ~port_direction_register;
  wire [7:0] p6_mask = port_is_p6_gp ? {{(8 - sc_pkg::SC_P6_GP_BITS){1'b0}},
                                        {sc_pkg::SC_P6_GP_BITS{1'b1}}} : 8'h00;
  wire [7:0] out_view = readback_ff ? (pin_sync & ~p6_mask) : port_latch;
  wire [7:0] nxt_port_rd = (out_mode & out_view) | (~out_mode & pin_sync);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      chan1_ff <= 1'b0;
      port_rd_ff <= sc_pkg::SC_RESET_BYTE;
    end else if (ce) begin
      chan1_ff <= nxt_chan1;
      port_rd_ff <= nxt_port_rd;
    end
  end

  assign chan1_capture_in = chan1_ff;
  assign port_read_data = port_rd_ff;

  // --------------------------------------------------------------------------
  // converter test source
  // --------------------------------------------------------------------------
  // code 01 is undefined and falls back to the normal channel
  assign converter_test_source = (conv_test_ff[sc_pkg::SC_BIT_TEST_HI]) ? conv_test_ff :
                                 sc_pkg::SC_SRC_CHANNEL;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  det_fire_a: assert property (ce && detect_en_ff && ng_hit && !fired_ff |=> reset_req_ff)
    else $error("illegal access did not raise reset");
  en_set_a: assert property (wr_guard && bus_wdata[7] |=> detect_en_ff)
    else $error("detect enable not set by write");
  en_sticky_a: assert property (detect_en_ff |=> detect_en_ff)
    else $error("detect enable cleared");
  wdt_force_a: assert property (ce && wdt_opt_ff && ng_hit && !fired_ff |=> reset_req_ff)
    else $error("watchdog option did not force detection");
  guard_rsv_a: assert property (ce && bus_rd && sel_guard |=>
                                !bus_rdata[6] && !bus_rdata[3])
    else $error("reserved guard bits read nonzero");
  ram_block_a: assert property (mem_valid && mem_write && ram_guard_ff != 2'h0 &&
                                sc_pkg::sc_in_range(mem_addr, sc_pkg::SC_RAM_START,
                                                    sc_pkg::SC_SIZE_128) |-> mem_wr_block)
    else $error("guarded ram write not blocked");
  grp_block_a: assert property (mem_valid && !mem_write |-> !mem_wr_block)
    else $error("read was blocked");
  tis_route_a: assert property (ce && timer_sel_ff == sc_pkg::SC_TIS_LOW_OSC |=>
                                chan1_ff == $past(losc_sync))
    else $error("oscillator not routed to channel 1");
  rb_p6_a: assert property (ce && readback_ff && port_is_p6_gp &&
                            port_direction_register == 8'h00 |=> port_rd_ff[4:0] == 5'h00)
    else $error("port 6 readback not zero");
  rb_bits_a: assert property (ce && bus_rd && sel_readback |=> bus_rdata[7:1] == 7'h00)
    else $error("readback upper bits nonzero");
  req_pulse_a: assert property (reset_req_ff |=> !reset_req_ff [*2])
    else $error("reset request longer than one pulse");

  fire_c: cover property (reset_req_ff);
  ram_c: cover property (mem_wr_block && ram_hit);
  rb_c: cover property (readback_ff && ce);
  osc_c: cover property (timer_sel_ff == 3'h4 && chan1_ff);

endmodule : sc_safety_ctl

// ==== tb/sc_pin_model.sv ====
`timescale 1ns/1ps
// --------------------------------------------------------------------------
// pin side: timer input pin, slow oscillator and port pin levels
// --------------------------------------------------------------------------
module sc_pin_model #(
  parameter int OSC_HALF = 6
) (
  // clock
  input wire logic clk_sys,
  // controls from the bench
  input wire logic ext_level,
  input wire logic osc_run,
  input wire logic [7:0] pin_drive,
  // pins
  output logic chan1_external_input,
  output logic low_speed_osc_clock,
  output logic [7:0] port_pin_level
);
  int osc_cnt;

  initial begin
    osc_cnt = 0;
    chan1_external_input = 1'b0;
    low_speed_osc_clock = 1'b0;
    port_pin_level = 8'h00;
  end

  // every phase lasts whole clock periods, far longer than one timer clock plus 10 ns
  always @(posedge clk_sys) begin
    chan1_external_input <= ext_level;
    port_pin_level <= pin_drive;
    if (osc_run && osc_cnt == OSC_HALF - 1) begin
      osc_cnt <= 0;
      low_speed_osc_clock <= ~low_speed_osc_clock;
    end else if (osc_run) begin
      osc_cnt <= osc_cnt + 1;
    end
  end
endmodule : sc_pin_model

// ==== tb/sc_safety_ctl_tb.sv ====
`timescale 1ns/1ps
module sc_safety_ctl_tb;
  logic clk_sys, rst, ce, bus_wr_byte, bus_wr_bit, bus_rd, mem_valid, mem_write;
  logic mem_grp_port, mem_grp_irq, mem_grp_csc, mem_wr_block, watchdog_run_option;
  logic illegal_access_reset_req, chan1_external_input, low_speed_osc_clock, chan1_capture_in;
  logic port_is_p6_gp, ext_level, osc_run;
  logic [19:0] bus_addr, mem_addr;
  logic [7:0] bus_wdata, bus_rdata, port_latch, port_pin_level, port_direction_register;
  logic [7:0] port_read_data, pin_drive;
  logic [1:0] converter_test_source;
  int fail_count = 0;
  int check_count = 0;
  int hi, lo;
  logic [7:0] codes [6] = '{8'h00, 8'h02, 8'h00, 8'h03, 8'h00, 8'h01};
  logic [1:0] srcs [6] = '{2'h0, 2'h2, 2'h0, 2'h3, 2'h0, 2'h0};

  sc_safety_ctl DUT (.clk_sys(clk_sys), .rst(rst), .ce(ce), .bus_addr(bus_addr),
    .bus_wr_byte(bus_wr_byte), .bus_wr_bit(bus_wr_bit), .bus_rd(bus_rd),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .mem_valid(mem_valid),
    .mem_write(mem_write), .mem_addr(mem_addr), .mem_grp_port(mem_grp_port),
    .mem_grp_irq(mem_grp_irq), .mem_grp_csc(mem_grp_csc), .mem_wr_block(mem_wr_block),
    .watchdog_run_option(watchdog_run_option),
    .illegal_access_reset_req(illegal_access_reset_req),
    .chan1_external_input(chan1_external_input), .low_speed_osc_clock(low_speed_osc_clock),
    .chan1_capture_in(chan1_capture_in), .port_latch(port_latch),
    .port_pin_level(port_pin_level), .port_direction_register(port_direction_register),
    .port_is_p6_gp(port_is_p6_gp), .port_read_data(port_read_data),
    .converter_test_source(converter_test_source));

  sc_pin_model PINS (.clk_sys(clk_sys), .ext_level(ext_level), .osc_run(osc_run),
    .pin_drive(pin_drive), .chan1_external_input(chan1_external_input),
    .low_speed_osc_clock(low_speed_osc_clock), .port_pin_level(port_pin_level));

  // --------------------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------------------
  task automatic close_out;
    if (fail_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    #1;
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [19:0] a, input logic [7:0] d, input logic bitop = 1'b0);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr_byte <= ~bitop;
    bus_wr_bit <= bitop;
    @(posedge clk_sys);
    bus_wr_byte <= 1'b0;
    bus_wr_bit <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [19:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    #1 chk("bus_rdata", exp, bus_rdata);
  endtask : rd

  // one access cycle: block is combinational, the reset request follows one cycle later
  task automatic acc(input logic [19:0] a, input logic w, input logic [2:0] g,
                     input logic blk, input logic req);
    @(posedge clk_sys);
    mem_valid <= 1'b1;
    mem_addr <= a;
    mem_write <= w;
    {mem_grp_port, mem_grp_irq, mem_grp_csc} <= g;
    #1 chk("mem_wr_block", {7'h00, blk}, {7'h00, mem_wr_block});
    @(posedge clk_sys);
    mem_valid <= 1'b0;
    #1 chk("illegal_access_reset_req", {7'h00, req}, {7'h00, illegal_access_reset_req});
  endtask : acc

  task automatic do_reset(input logic opt);
    @(posedge clk_sys);
    rst <= 1'b1;
    watchdog_run_option <= opt;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
  endtask : do_reset

  // --------------------------------------------------------------------------
  // clock, time limit, sequence
  // --------------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    close_out();
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    bus_addr = 20'h0_0000;
    bus_wdata = 8'h00;
    bus_wr_byte = 1'b0;
    bus_wr_bit = 1'b0;
    bus_rd = 1'b0;
    mem_valid = 1'b0;
    mem_write = 1'b0;
    mem_addr = 20'h0_0000;
    mem_grp_port = 1'b0;
    mem_grp_irq = 1'b0;
    mem_grp_csc = 1'b0;
    watchdog_run_option = 1'b0;
    port_latch = 8'h00;
    port_direction_register = 8'h00;
    port_is_p6_gp = 1'b0;
    ext_level = 1'b0;
    osc_run = 1'b0;
    pin_drive = 8'h00;
    do_reset(1'b0);
    rd(sc_pkg::SC_ADDR_TIMER_SEL, 8'h00);
    rd(sc_pkg::SC_ADDR_GUARD_CTL, 8'h00);
    rd(sc_pkg::SC_ADDR_READBACK, 8'h00);
    rd(20'hF_0070, 8'h00);
    chk("converter_test_source", 8'h00, {6'h00, converter_test_source});
    // a write while the clock enable is low must not land
    ce <= 1'b0;
    wr(sc_pkg::SC_ADDR_TIMER_SEL, 8'h04);
    ce <= 1'b1;
    rd(sc_pkg::SC_ADDR_TIMER_SEL, 8'h00);
    wr(sc_pkg::SC_ADDR_READBACK, 8'hFF);
    rd(sc_pkg::SC_ADDR_READBACK, 8'h01);
    wr(sc_pkg::SC_ADDR_READBACK, 8'h00, 1'b1);
    rd(sc_pkg::SC_ADDR_READBACK, 8'h00);
    port_latch <= 8'hA5;
    pin_drive <= 8'h5A;
    wr(sc_pkg::SC_ADDR_READBACK, 8'h01, 1'b1);
    repeat (6) @(posedge clk_sys);
    chk("port_read_data", 8'h5A, port_read_data);
    port_is_p6_gp <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk("port_read_data", 8'h40, port_read_data);
    port_is_p6_gp <= 1'b0;
    wr(sc_pkg::SC_ADDR_READBACK, 8'h00);
    repeat (6) @(posedge clk_sys);
    chk("port_read_data", 8'hA5, port_read_data);
    port_direction_register <= 8'hF0;
    repeat (6) @(posedge clk_sys);
    chk("port_read_data", 8'h55, port_read_data);
    ext_level <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk("chan1_capture_in", 8'h01, {7'h00, chan1_capture_in});
    ext_level <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk("chan1_capture_in", 8'h00, {7'h00, chan1_capture_in});
    wr(sc_pkg::SC_ADDR_TIMER_SEL, 8'h04);
    wr(sc_pkg::SC_ADDR_TIMER_SEL, 8'h00, 1'b1);
    rd(sc_pkg::SC_ADDR_TIMER_SEL, 8'h04);
    osc_run <= 1'b1;
    ext_level <= 1'b1;
    hi = 0;
    lo = 0;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk_sys);
      #1;
      if (chan1_capture_in === 1'b1) hi++;
      if (chan1_capture_in === 1'b0) lo++;
    end
    chk("chan1_capture_in toggles", 8'h01, {7'h00, hi > 8 && lo > 8});
    for (int c = 1; c < 8; c++) begin
      if (c == 4) continue;
      wr(sc_pkg::SC_ADDR_TIMER_SEL, 8'(c));
      repeat (6) @(posedge clk_sys);
      chk("chan1_capture_in", 8'h00, {7'h00, chan1_capture_in});
    end
    for (int i = 0; i < 6; i++) begin
      wr(sc_pkg::SC_ADDR_CONV_TEST, codes[i]);
      chk("converter_test_source", {6'h00, srcs[i]}, {6'h00, converter_test_source});
    end
    wr(sc_pkg::SC_ADDR_CONV_TEST, 8'h00);
    for (int s = 1; s < 4; s++) begin
      wr(sc_pkg::SC_ADDR_GUARD_CTL, 8'(s << 4));
      acc(sc_pkg::SC_RAM_START + (20'h0_0080 << (s - 1)) - 20'h0_0001,
          1'b1, 3'h0, 1'b1, 1'b0);
      acc(sc_pkg::SC_RAM_START + (20'h0_0080 << (s - 1)), 1'b1, 3'h0, 1'b0, 1'b0);
      acc(sc_pkg::SC_RAM_START, 1'b0, 3'h0, 1'b0, 1'b0);
    end
    for (int g = 0; g < 3; g++) begin
      wr(sc_pkg::SC_ADDR_GUARD_CTL, 8'h01 << g);
      acc(20'hF_0020, 1'b1, 3'h1 << g, 1'b1, 1'b0);
      acc(20'hF_0020, 1'b0, 3'h1 << g, 1'b0, 1'b0);
      acc(20'hF_0020, 1'b1, 3'h1 << ((g + 1) % 3), 1'b0, 1'b0);
    end
    wr(sc_pkg::SC_ADDR_GUARD_CTL, 8'h37);
    rd(sc_pkg::SC_ADDR_GUARD_CTL, 8'h37);
    acc(20'hE_0000, 1'b0, 3'h0, 1'b0, 1'b0);
    wr(sc_pkg::SC_ADDR_GUARD_CTL, 8'h80);
    rd(sc_pkg::SC_ADDR_GUARD_CTL, 8'h80);
    wr(sc_pkg::SC_ADDR_GUARD_CTL, 8'h00);
    rd(sc_pkg::SC_ADDR_GUARD_CTL, 8'h80);
    acc(20'hD_FFFF, 1'b0, 3'h0, 1'b0, 1'b0);
    acc(20'hF_0000, 1'b1, 3'h0, 1'b0, 1'b0);
    acc(20'hE_FFFF, 1'b0, 3'h0, 1'b0, 1'b1);
    @(posedge clk_sys);
    #1 chk("illegal_access_reset_req", 8'h00, {7'h00, illegal_access_reset_req});
    acc(20'hE_0000, 1'b1, 3'h0, 1'b0, 1'b0);
    do_reset(1'b1);
    rd(sc_pkg::SC_ADDR_GUARD_CTL, 8'h00);
    acc(20'hE_0000, 1'b0, 3'h0, 1'b0, 1'b1);
    close_out();
  end
endmodule : sc_safety_ctl_tb
